// *** src/controller_system_flag_bank.sv ***
// controller system flag bank with avalon-mm register access
// What this block does
// - one error flag per remote slave follows that slave's link error
// - write/adjust error flag sets on failed write, clears on success
// - read error flag sets on failed copy to current words, clears on success
// - date, time or combined trigger loads matching new words into clock
// - adjust zeroes seconds; from 30 up also adds one minute
// - port 2 or port 3 cancel bit rising cancels that port's receives
// - block move busy flag spans the move and survives reset
// - stopped cpu turns outputs off unless hold bit; restart clears hold
// - card present and card writing flags follow card state
// - six interrupt allowed bits, all cleared when inputs disabled
// - card access stop acts on rising edge only
// - per interrupt edge select: one rising, zero falling
// - catch inputs latch level on any edge, once per scan
// - network cancel bit rising cancels receives on that connection
// - connection status bits follow peers; zero without ethernet
// - initialize pulse stands exactly one scan after cpu start
// - one-second square wave, 500 ms on and 500 ms off
// - in-operation bit is on while cpu runs
// - disconnect bit rising drops client connection only, needs ethernet
// - timer interrupt status follows timer interrupt enable
// - compare sets exactly one of greater, equal, less
// - one-second reset bit forces one-second square off
`timescale 1ns/1ps

module half_period_square #(
	parameter int HALF_MS = 5
) (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic ms_tick_i,
	input wire logic hold_i,
	output logic square_o
);
	localparam int CW = $clog2(HALF_MS) + 1;
	logic [CW-1:0] cnt_r;

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i || hold_i)
		begin
			cnt_r <= '0;
			square_o <= 1'b0;
		end
		else if (ms_tick_i)
		begin
			if (cnt_r == CW'(HALF_MS - 1))
			begin
				cnt_r <= '0;
				square_o <= ~square_o;
			end
			else
				cnt_r <= cnt_r + 1'b1;
		end
	end
endmodule : half_period_square

module controller_system_flag_bank #(
	parameter int OUT_W = 16,
	parameter int CMP_W = 16,
	parameter bit HAS_ETHERNET = 1'b1,
	parameter int CYC_PER_MS_P = flag_bank_pkg::CYC_PER_MS
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	// avalon-mm slave
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// cpu state and scan
	input wire logic cpu_run_i,
	input wire logic scan_end_i,
	// status sources
	input wire logic [2:0] remote_link_error_i,
	input wire logic clock_read_fault_i,
	input wire logic block_move_start_i,
	input wire logic block_move_done_i,
	input wire logic card_inserted_i,
	input wire logic card_logging_i,
	input wire logic [5:0] int_enable_i,
	input wire logic int_inputs_disabled_i,
	input wire logic timer_int_enable_i,
	input wire logic [5:0] irq_pins_i,
	input wire logic [5:0] catch_pins_i,
	input wire logic [2:0] net_connected_i,
	input wire logic [2:0] net_client_mode_i,
	input wire logic [OUT_W-1:0] user_outputs_i,
	// actions
	output logic [OUT_W-1:0] plant_outputs_o,
	output logic [5:0] irq_event_o,
	output logic port2_cancel_o,
	output logic port3_cancel_o,
	output logic [2:0] net_cancel_o,
	output logic [2:0] client_drop_o,
	output logic card_stop_o
);
	import flag_bank_pkg::*;

	localparam int DIV_W = $clog2(CYC_PER_MS_P);
	if (CYC_PER_MS_P < 2 || OUT_W < 1 || CMP_W < 1 || CMP_W > 32)
		$error("flag bank parameters out of range");

	bus_state_e bus_r;
	ctrl_s ctrl_r, ctrl_nxt, prev_r, rise;
	status_s st;
	logic [DIV_W-1:0] ms_div_r;
	logic ms_tick_r;
	logic [9:0] ms_in_sec_r;
	logic one_sq, hund_sq, ten_sq;
	logic [7:0] rtc_r [WORDS];
	logic [7:0] rtc_nxt [WORDS];
	logic [7:0] nw_r [WORDS];
	logic [7:0] cur_r [WORDS];
	logic [2:0] remote_r;
	logic tw_err_r, tw_err_nxt, tr_err_r;
	logic busy_r = 1'b0;
	logic card_pr_r, card_wr_r, run_prev_r, init_r, inop_r, timer_r;
	logic [5:0] allowed_r, irq_prev_r, catch_prev_r, caught_r, catch_r;
	logic [2:0] conn_r;
	logic [CMP_W-1:0] cmp_a_r;
	logic greater_r, equal_r, less_r;
	logic [31:0] rdata_r;

	// bus decode
	wire req = avs_read_i | avs_write_i;
	wire accept = (bus_r == BUS_ACK);
	wire wr_go = accept & avs_write_i;
	wire aligned = (avs_address_i[1:0] == 2'b00);
	wire [2:0] widx = avs_address_i[4:2];
	wire win_ok = aligned & (widx < 3'(WORDS));
	wire hit_new = win_ok & (avs_address_i[7:5] == NEW_BASE[7:5]);
	wire hit_cur = win_ok & (avs_address_i[7:5] == CUR_BASE[7:5]);
	wire wr_ctrl = wr_go & (avs_address_i == ADDR_CTRL);
	wire wr_cmp_a = wr_go & (avs_address_i == ADDR_CMP_A);
	wire wr_cmp_b = wr_go & (avs_address_i == ADDR_CMP_B);
	wire wr_new = wr_go & hit_new;
	wire [31:0] inputs_word = {13'h0000, conn_r, 2'b00, catch_r, 2'b00, allowed_r};
	wire [31:0] rdata_sel =
		(avs_address_i == ADDR_CTRL) ? 32'(ctrl_r) :
		(avs_address_i == ADDR_STATUS) ? 32'(st) :
		(avs_address_i == ADDR_INPUTS) ? inputs_word :
		(avs_address_i == ADDR_CMP_A) ? 32'(cmp_a_r) :
		hit_cur ? {24'h000000, cur_r[widx]} : 32'h0000_0000;

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
			bus_r <= BUS_IDLE;
		else
			case (bus_r)
				BUS_IDLE: bus_r <= req ? BUS_ACK : BUS_IDLE;
				BUS_ACK: bus_r <= BUS_IDLE;
				default: bus_r <= BUS_IDLE;
			endcase
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
			rdata_r <= 32'h0000_0000;
		else if (bus_r == BUS_IDLE && avs_read_i)
			rdata_r <= rdata_sel;
	end

	assign avs_readdata_o = rdata_r;
	// idle bit of the one-hot state doubles as waitrequest, straight from the flop
	assign avs_waitrequest_o = bus_r[0];

	// command edges and control register
	wire run_rise = cpu_run_i & ~run_prev_r;
	assign rise = ctrl_r & ~prev_r;

	always_comb
	begin
		ctrl_nxt = ctrl_r;
		if (run_rise)
			ctrl_nxt.hold_outputs_on_stop = 1'b0;
		if (wr_ctrl)
			ctrl_nxt = ctrl_s'(avs_writedata_i);
		ctrl_nxt.pad_hi = '0;
		ctrl_nxt.pad_mid = 1'b0;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			ctrl_r <= ctrl_s'(CTRL_RST);
			prev_r <= ctrl_s'(CTRL_RST);
		end
		else
		begin
			ctrl_r <= ctrl_nxt;
			prev_r <= ctrl_r;
		end
	end

	// millisecond base and square waves
	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i || ms_div_r == DIV_W'(CYC_PER_MS_P - 1))
			ms_div_r <= '0;
		else
			ms_div_r <= ms_div_r + 1'b1;
		ms_tick_r <= ~sys_rst_i & (ms_div_r == DIV_W'(CYC_PER_MS_P - 1));
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i || (ms_tick_r && ms_in_sec_r == 10'(SEC_MS - 1)))
			ms_in_sec_r <= '0;
		else if (ms_tick_r)
			ms_in_sec_r <= ms_in_sec_r + 1'b1;
	end

	half_period_square #(.HALF_MS(ONE_HALF_MS)) u_one_sq (
		.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .ms_tick_i(ms_tick_r),
		.hold_i(ctrl_r.one_second_reset), .square_o(one_sq));
	half_period_square #(.HALF_MS(HUND_HALF_MS)) u_hund_sq (
		.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .ms_tick_i(ms_tick_r),
		.hold_i(1'b0), .square_o(hund_sq));
	half_period_square #(.HALF_MS(TEN_HALF_MS)) u_ten_sq (
		.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .ms_tick_i(ms_tick_r),
		.hold_i(1'b0), .square_o(ten_sq));

	// calendar clock
	wire sec_tick = ms_tick_r & (ms_in_sec_r == 10'(SEC_MS - 1));
	wire copy_tick = ms_tick_r & ((ms_in_sec_r == 10'(COPY_MS - 1)) | sec_tick);
	wire load_date = rise.date_write_trigger | rise.datetime_write_trigger;
	wire load_time = rise.time_write_trigger | rise.datetime_write_trigger;
	wire date_ok = (nw_r[W_YEAR] <= 8'(YEAR_MAX)) & (nw_r[W_MONTH] != 8'h00) &
		(nw_r[W_MONTH] <= 8'(MONTH_MAX)) & (nw_r[W_DAY] != 8'h00) &
		(nw_r[W_DAY] <= 8'(DAY_MAX)) & (nw_r[W_WDAY] <= 8'(WDAY_MAX));
	wire time_ok = (nw_r[W_HOUR] <= 8'(HOUR_MAX)) & (nw_r[W_MIN] <= 8'(MIN_MAX)) &
		(nw_r[W_SEC] <= 8'(SEC_MAX));
	wire write_ok = (~load_date | date_ok) & (~load_time | time_ok);
	wire min_wrap = (rtc_r[W_MIN] == 8'(MIN_MAX));
	wire [7:0] min_up = min_wrap ? 8'h00 : 8'(rtc_r[W_MIN] + 8'h01);
	wire [7:0] hour_up = ~min_wrap ? rtc_r[W_HOUR] :
		(rtc_r[W_HOUR] == 8'(HOUR_MAX)) ? 8'h00 : 8'(rtc_r[W_HOUR] + 8'h01);

	always_comb
	begin
		rtc_nxt = rtc_r;
		tw_err_nxt = tw_err_r;
		if (load_date || load_time)
		begin
			tw_err_nxt = ~write_ok;
			for (int i = 0; i < WORDS; i++)
				if (write_ok && ((i <= W_WDAY) ? load_date : load_time))
					rtc_nxt[i] = nw_r[i];
		end
		else if (rise.clock_adjust_trigger)
		begin
			tw_err_nxt = 1'b0;
			rtc_nxt[W_SEC] = 8'h00;
			if (rtc_r[W_SEC] >= 8'(ADJ_ROUND_SEC))
			begin
				rtc_nxt[W_MIN] = min_up;
				rtc_nxt[W_HOUR] = hour_up;
			end
		end
		else if (sec_tick)
		begin
			if (rtc_r[W_SEC] == 8'(SEC_MAX))
			begin
				rtc_nxt[W_SEC] = 8'h00;
				rtc_nxt[W_MIN] = min_up;
				rtc_nxt[W_HOUR] = hour_up;
			end
			else
				rtc_nxt[W_SEC] = 8'(rtc_r[W_SEC] + 8'h01);
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			for (int i = 0; i < WORDS; i++)
			begin
				rtc_r[i] <= (i == W_MONTH || i == W_DAY) ? 8'h01 : 8'h00;
				nw_r[i] <= 8'h00;
				cur_r[i] <= 8'h00;
			end
			tw_err_r <= 1'b0;
			tr_err_r <= 1'b0;
		end
		else
		begin
			rtc_r <= rtc_nxt;
			tw_err_r <= tw_err_nxt;
			if (wr_new)
				nw_r[widx] <= avs_writedata_i[7:0];
			if (copy_tick)
			begin
				tr_err_r <= clock_read_fault_i;
				if (!clock_read_fault_i)
					cur_r <= rtc_r;
			end
		end
	end

	// block move busy is battery backed, so reset leaves it alone
	always_ff @(posedge clk_sys_i)
	begin
		if (block_move_start_i)
			busy_r <= 1'b1;
		else if (block_move_done_i)
			busy_r <= 1'b0;
	end

	// live status, cpu state, outputs
	wire [5:0] irq_rise = irq_pins_i & ~irq_prev_r;
	wire [5:0] irq_fall = ~irq_pins_i & irq_prev_r;
	wire [5:0] catch_take = (catch_pins_i ^ catch_prev_r) & ~caught_r;
	wire eth = HAS_ETHERNET;

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			{remote_r, card_pr_r, card_wr_r, timer_r, run_prev_r, inop_r, init_r} <= '0;
			{allowed_r, irq_prev_r, irq_event_o, conn_r} <= '0;
			{catch_prev_r, caught_r, catch_r} <= '0;
			{port2_cancel_o, port3_cancel_o, net_cancel_o, client_drop_o, card_stop_o} <= '0;
			plant_outputs_o <= '0;
		end
		else
		begin
			remote_r <= remote_link_error_i;
			card_pr_r <= card_inserted_i;
			card_wr_r <= card_logging_i;
			timer_r <= timer_int_enable_i;
			run_prev_r <= cpu_run_i;
			inop_r <= cpu_run_i;
			if (run_rise)
				init_r <= 1'b1;
			else if (scan_end_i || !cpu_run_i)
				init_r <= 1'b0;
			allowed_r <= int_enable_i & {6{~int_inputs_disabled_i}};
			irq_prev_r <= irq_pins_i;
			irq_event_o <= allowed_r & ((ctrl_r.interrupt_edge_select & irq_rise) |
				(~ctrl_r.interrupt_edge_select & irq_fall));
			conn_r <= net_connected_i & {3{eth}};
			catch_prev_r <= catch_pins_i;
			catch_r <= (catch_r & ~catch_take) | (catch_pins_i & catch_take);
			caught_r <= (caught_r & ~{6{scan_end_i}}) | catch_take;
			port2_cancel_o <= rise.port2_receive_cancel;
			port3_cancel_o <= rise.port3_receive_cancel;
			net_cancel_o <= rise.net_receive_cancel;
			client_drop_o <= rise.client_disconnect_cmd & net_client_mode_i & {3{eth}};
			card_stop_o <= rise.card_access_stop;
			if (cpu_run_i)
				plant_outputs_o <= user_outputs_i;
			else if (!ctrl_r.hold_outputs_on_stop)
				plant_outputs_o <= '0;
		end
	end

	// compare on write of the second operand
	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
			{cmp_a_r, greater_r, equal_r, less_r} <= '0;
		else if (wr_cmp_a)
			cmp_a_r <= avs_writedata_i[CMP_W-1:0];
		else if (wr_cmp_b)
		begin
			greater_r <= cmp_a_r > avs_writedata_i[CMP_W-1:0];
			equal_r <= cmp_a_r == avs_writedata_i[CMP_W-1:0];
			less_r <= cmp_a_r < avs_writedata_i[CMP_W-1:0];
		end
	end

	always_comb
	begin
		st = '0;
		st.remote_slave_error = remote_r;
		st.time_write_error = tw_err_r;
		st.time_read_error = tr_err_r;
		st.block_move_busy = busy_r;
		st.card_present = card_pr_r;
		st.card_writing = card_wr_r;
		st.initialize_pulse = init_r;
		st.one_second_square = one_sq;
		st.hundred_ms_square = hund_sq;
		st.ten_ms_square = ten_sq;
		st.in_operation = inop_r;
		st.timer_interrupt_status = timer_r;
		st.compare_greater = greater_r;
		st.compare_equal = equal_r;
		st.compare_less = less_r;
	end

	// checks
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);

	a_remote_err_follow: assert property (
		##1 remote_r == $past(remote_link_error_i)) else $error("remote error flag lags");
	a_init_pulse_start: assert property (
		run_rise |=> init_r) else $error("initialize pulse missing");
	a_init_pulse_end: assert property (
		init_r && scan_end_i && !run_rise |=> !init_r) else $error("pulse longer than scan");
	a_hold_auto_clear: assert property (
		run_rise && !wr_ctrl |=> !ctrl_r.hold_outputs_on_stop) else $error("hold not cleared");
	a_outputs_off_stop: assert property (
		!cpu_run_i && !ctrl_r.hold_outputs_on_stop |=> plant_outputs_o == '0)
		else $error("outputs left on at stop");
	a_one_sec_forced: assert property (
		ctrl_r.one_second_reset |=> !one_sq) else $error("one second wave not forced off");
	a_cancel_one_pulse: assert property (
		rise.port2_receive_cancel |=> port2_cancel_o ##1 !port2_cancel_o)
		else $error("port 2 cancel not a single pulse");
	a_drop_client_only: assert property (
		client_drop_o != 3'b000 |-> eth && ((client_drop_o & ~$past(net_client_mode_i)) == 0))
		else $error("server or ethernetless drop");
	a_compare_result: assert property (
		wr_cmp_b |=> $onehot({greater_r, equal_r, less_r}) &&
		greater_r == ($past(cmp_a_r) > $past(avs_writedata_i[CMP_W-1:0])))
		else $error("compare result wrong");
	a_adjust_zero_sec: assert property (
		rise.clock_adjust_trigger && !load_date && !load_time |=> rtc_r[W_SEC] == 8'h00)
		else $error("adjust left seconds");
	a_bus_answer: assert property (
		req && bus_r == BUS_IDLE |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
		else $error("bus answer timing");

	c_init_pulse: cover property (run_rise ##1 init_r);
	c_catch_taken: cover property (catch_take != 6'h00);
	c_clock_write: cover property (load_time && write_ok);
	c_irq_event: cover property (irq_event_o != 6'h00);
endmodule : controller_system_flag_bank

// *** src/flag_bank_pkg.sv ***
// constants, register map and field layouts of the controller flag bank
package flag_bank_pkg;
	localparam int CLK_PERIOD_NS = 50;
	localparam int MS_NS = 1_000_000;
	localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
	localparam int TEN_HALF_MS = 5;
	localparam int HUND_HALF_MS = 50;
	localparam int ONE_HALF_MS = 500;
	localparam int SEC_MS = 1000;
	localparam int COPY_MS = 500;
	localparam int ADJ_ROUND_SEC = 30;
	localparam int YEAR_MAX = 99;
	localparam int MONTH_MAX = 12;
	localparam int DAY_MAX = 31;
	localparam int WDAY_MAX = 6;
	localparam int HOUR_MAX = 23;
	localparam int MIN_MAX = 59;
	localparam int SEC_MAX = 59;
	localparam int WORDS = 7;
	localparam int W_YEAR = 0;
	localparam int W_MONTH = 1;
	localparam int W_DAY = 2;
	localparam int W_WDAY = 3;
	localparam int W_HOUR = 4;
	localparam int W_MIN = 5;
	localparam int W_SEC = 6;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_INPUTS = 8'h08;
	localparam logic [7:0] ADDR_CMP_A = 8'h0C;
	localparam logic [7:0] ADDR_CMP_B = 8'h10;
	localparam logic [7:0] NEW_BASE = 8'h20;
	localparam logic [7:0] CUR_BASE = 8'h40;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;

	typedef enum logic [1:0] {BUS_IDLE = 2'b01, BUS_ACK = 2'b10} bus_state_e;

	typedef struct packed {
		logic [9:0] pad_hi;
		logic [5:0] interrupt_edge_select;
		logic pad_mid;
		logic [2:0] client_disconnect_cmd;
		logic [2:0] net_receive_cancel;
		logic one_second_reset;
		logic card_access_stop;
		logic hold_outputs_on_stop;
		logic port3_receive_cancel;
		logic port2_receive_cancel;
		logic clock_adjust_trigger;
		logic datetime_write_trigger;
		logic time_write_trigger;
		logic date_write_trigger;
	} ctrl_s;

	typedef struct packed {
		logic [14:0] pad_hi;
		logic compare_less;
		logic compare_equal;
		logic compare_greater;
		logic timer_interrupt_status;
		logic in_operation;
		logic ten_ms_square;
		logic hundred_ms_square;
		logic one_second_square;
		logic initialize_pulse;
		logic card_writing;
		logic card_present;
		logic block_move_busy;
		logic time_read_error;
		logic time_write_error;
		logic [2:0] remote_slave_error;
	} status_s;
endpackage : flag_bank_pkg

// *** bench/tb.sv ***
// self-checking bench for the controller system flag bank
`timescale 1ns/1ps
module tb;
	import flag_bank_pkg::*;
	logic clk_sys_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [7:0] adr = 8'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic wait_o;
	logic run = 1'b0;
	logic scan = 1'b0;
	logic [2:0] lerr = 3'h0;
	logic rfault = 1'b0;
	logic bm_start = 1'b0;
	logic bm_done = 1'b0;
	logic card_in = 1'b0;
	logic card_log = 1'b0;
	logic [5:0] int_en = 6'h00;
	logic int_dis = 1'b0;
	logic tmr_en = 1'b0;
	logic [5:0] irq = 6'h00;
	logic [5:0] catch_p = 6'h00;
	logic [2:0] conn = 3'h0;
	logic [2:0] client = 3'h7;
	logic [15:0] uout = 16'h0000;
	logic [15:0] pout;
	logic [5:0] irq_ev;
	logic p2c;
	logic p3c;
	logic cstop;
	logic [2:0] ncan;
	logic [2:0] cdrop;
	wire [8:0] act = {cstop, cdrop, ncan, p3c, p2c};
	logic [31:0] ctrl = 32'h0;
	logic [31:0] v;
	int n_mismatch = 0;
	int compares = 0;
	int cyc = 0;

	always #25 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) cyc <= cyc + 1;

	controller_system_flag_bank #(.CYC_PER_MS_P(4)) DUT (
		.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
		.avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
		.avs_readdata_o(rdat), .avs_waitrequest_o(wait_o),
		.cpu_run_i(run), .scan_end_i(scan), .remote_link_error_i(lerr),
		.clock_read_fault_i(rfault), .block_move_start_i(bm_start), .block_move_done_i(bm_done),
		.card_inserted_i(card_in), .card_logging_i(card_log), .int_enable_i(int_en),
		.int_inputs_disabled_i(int_dis), .timer_int_enable_i(tmr_en), .irq_pins_i(irq),
		.catch_pins_i(catch_p), .net_connected_i(conn), .net_client_mode_i(client),
		.user_outputs_i(uout), .plant_outputs_o(pout), .irq_event_o(irq_ev),
		.port2_cancel_o(p2c), .port3_cancel_o(p3c), .net_cancel_o(ncan),
		.client_drop_o(cdrop), .card_stop_o(cstop)
	);

	task end_sim;
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_sim

	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			$display("wrong value %s expected %h seen %h", nm, exp, got);
			n_mismatch++;
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask : tick

	// one avalon access, called right after a rising edge
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		adr <= a;
		wdat <= d;
		wr <= w;
		rd <= !w;
		do
		begin
			@(posedge clk_sys_i);
			n++;
		end
		while (wait_o !== 1'b0 && n < 50);
		v = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		if (wait_o !== 1'b0)
		begin
			n_mismatch++;
			end_sim();
		end
		else
			@(posedge clk_sys_i);
	endtask : bus

	task rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
		bus(1'b0, a, 32'h0);
		chk(nm, v & m, e);
	endtask : rd_chk

	task setc(input int b, input logic val);
		ctrl[b] = val;
		bus(1'b1, ADDR_CTRL, ctrl);
	endtask : setc

	// collects the action pulses over eight edges
	task watch(input logic m, input logic [8:0] exp);
		logic [8:0] seen;
		int cnt;
		seen = 9'h0;
		cnt = 0;
		repeat (8)
		begin
			@(posedge clk_sys_i);
			seen |= m ? {3'h0, irq_ev} : act;
			cnt += m ? $countones(irq_ev) : $countones(act);
		end
		chk("pulse", seen, exp);
		chk("width", cnt, $countones(exp));
	endtask : watch

	// time between two seen toggles of a status bit, within four cycles of slack
	task halfp(input int b, input int ce);
		int t0;
		logic s;
		t0 = 0;
		bus(1'b0, ADDR_STATUS, 32'h0);
		for (int k = 0; k < 2; k++)
		begin
			s = v[b];
			for (int n = 0; n < 3000 && v[b] === s; n++)
				bus(1'b0, ADDR_STATUS, 32'h0);
			if (k == 0)
				t0 = cyc;
		end
		chk("half", (cyc - t0 > ce - 5) && (cyc - t0 < ce + 5), 1'b1);
	endtask : halfp

	task t_reset;
		rd_chk(ADDR_CTRL, 32'hFFFF_FFFF, CTRL_RST, "ctrl");
		rd_chk(ADDR_STATUS, 32'hFFFF_F1DF, 32'h0, "status");
		bus(1'b1, 8'h24, 32'h5);
		rd_chk(8'h24, 32'hFFFF_FFFF, 32'h0, "new_word");
		rd_chk(8'h80, 32'hFFFF_FFFF, 32'h0, "unmapped");
	endtask : t_reset

	task t_status;
		lerr <= 3'h5;
		card_in <= 1'b1;
		card_log <= 1'b1;
		tmr_en <= 1'b1;
		conn <= 3'h6;
		tick(2);
		rd_chk(ADDR_STATUS, 32'h20C7, 32'h20C5, "status");
		rd_chk(ADDR_INPUTS, 32'h7_0000, 32'h6_0000, "conn");
		lerr <= 3'h2;
		card_log <= 1'b0;
		tmr_en <= 1'b0;
		conn <= 3'h1;
		tick(2);
		rd_chk(ADDR_STATUS, 32'h20C7, 32'h0042, "status");
		rd_chk(ADDR_INPUTS, 32'h7_0000, 32'h1_0000, "conn");
	endtask : t_status

	task automatic t_cmp;
		logic [31:0] ca[3] = '{32'h7, 32'h5, 32'h0};
		logic [31:0] cb[3] = '{32'h3, 32'h5, 32'h7FFF};
		logic [31:0] ce[3] = '{32'h4000, 32'h8000, 32'h1_0000};
		for (int i = 0; i < 3; i++)
		begin
			bus(1'b1, ADDR_CMP_A, ca[i]);
			bus(1'b1, ADDR_CMP_B, cb[i]);
			rd_chk(ADDR_STATUS, 32'h1_C000, ce[i], "compare");
		end
	endtask : t_cmp

	task automatic t_cmd;
		int bits[9] = '{4, 5, 9, 10, 11, 12, 13, 14, 7};
		for (int i = 0; i < 9; i++)
		begin
			setc(bits[i], 1'b1);
			watch(1'b0, 9'h1 << i);
			setc(bits[i], 1'b0);
			watch(1'b0, 9'h0);
		end
		client <= 3'h6;
		setc(12, 1'b1);
		watch(1'b0, 9'h0);
		setc(12, 1'b0);
	endtask : t_cmd

	task t_hold;
		uout <= 16'hA5C3;
		run <= 1'b1;
		tick(3);
		rd_chk(ADDR_STATUS, 32'h1100, 32'h1100, "run");
		chk("plant", pout, 16'hA5C3);
		scan <= 1'b1;
		tick(1);
		scan <= 1'b0;
		tick(2);
		rd_chk(ADDR_STATUS, 32'h1100, 32'h1000, "init");
		run <= 1'b0;
		tick(3);
		chk("plant", pout, 16'h0);
		rd_chk(ADDR_STATUS, 32'h1000, 32'h0, "stop");
		run <= 1'b1;
		tick(3);
		setc(6, 1'b1);
		run <= 1'b0;
		tick(3);
		chk("plant", pout, 16'hA5C3);
		run <= 1'b1;
		tick(3);
		ctrl[6] = 1'b0;
		rd_chk(ADDR_CTRL, 32'h40, 32'h0, "hold");
	endtask : t_hold

	task t_irq_catch;
		int_en <= 6'h3F;
		setc(16, 1'b1);
		rd_chk(ADDR_INPUTS, 32'h3F, 32'h3F, "allowed");
		irq <= 6'h03;
		watch(1'b1, 9'h1);
		irq <= 6'h00;
		watch(1'b1, 9'h2);
		int_dis <= 1'b1;
		tick(2);
		rd_chk(ADDR_INPUTS, 32'h3F, 32'h0, "allowed");
		int_dis <= 1'b0;
		catch_p <= 6'h04;
		tick(3);
		rd_chk(ADDR_INPUTS, 32'h400, 32'h400, "catch");
		scan <= 1'b1;
		tick(1);
		scan <= 1'b0;
		catch_p <= 6'h00;
		tick(3);
		rd_chk(ADDR_INPUTS, 32'h400, 32'h0, "catch");
		catch_p <= 6'h04;
		tick(3);
		rd_chk(ADDR_INPUTS, 32'h400, 32'h0, "catch");
	endtask : t_irq_catch

	task t_bm;
		bm_start <= 1'b1;
		tick(1);
		bm_start <= 1'b0;
		tick(2);
		rd_chk(ADDR_STATUS, 32'h20, 32'h20, "busy");
		bm_done <= 1'b1;
		tick(1);
		bm_done <= 1'b0;
		tick(2);
		rd_chk(ADDR_STATUS, 32'h20, 32'h0, "busy");
	endtask : t_bm

	task automatic t_clock;
		logic [31:0] nw[7] = '{25, 3, 14, 2, 23, 10, 45};
		for (int i = 0; i < 7; i++)
			bus(1'b1, NEW_BASE + 8'(4 * i), nw[i]);
		setc(2, 1'b1);
		setc(2, 1'b0);
		rd_chk(ADDR_STATUS, 32'h8, 32'h0, "wr_err");
		setc(3, 1'b1);
		setc(3, 1'b0);
		tick(2100);
		rd_chk(CUR_BASE, 32'hFF, 32'd25, "year");
		rd_chk(CUR_BASE + 8'h10, 32'hFF, 32'd23, "hour");
		rd_chk(CUR_BASE + 8'h14, 32'hFF, 32'd11, "minute");
		bus(1'b0, CUR_BASE + 8'h18, 32'h0);
		chk("second", v < 2, 1'b1);
		rd_chk(ADDR_STATUS, 32'h10, 32'h0, "rd_err");
		bus(1'b1, NEW_BASE + 8'h04, 32'd13);
		setc(0, 1'b1);
		setc(0, 1'b0);
		rd_chk(ADDR_STATUS, 32'h8, 32'h8, "wr_err");
		bus(1'b1, NEW_BASE + 8'h04, 32'd4);
		setc(0, 1'b1);
		setc(0, 1'b0);
		rd_chk(ADDR_STATUS, 32'h8, 32'h0, "wr_err");
		bus(1'b1, NEW_BASE + 8'h10, 32'd24);
		setc(1, 1'b1);
		setc(1, 1'b0);
		rd_chk(ADDR_STATUS, 32'h8, 32'h8, "wr_err");
		bus(1'b1, NEW_BASE + 8'h10, 32'd23);
		bus(1'b1, NEW_BASE + 8'h18, 32'd20);
		setc(1, 1'b1);
		setc(1, 1'b0);
		rd_chk(ADDR_STATUS, 32'h8, 32'h0, "wr_err");
		setc(3, 1'b1);
		setc(3, 1'b0);
		tick(2100);
		rd_chk(CUR_BASE + 8'h04, 32'hFF, 32'd4, "month");
		rd_chk(CUR_BASE + 8'h14, 32'hFF, 32'd10, "minute");
		rfault <= 1'b1;
		tick(2100);
		rd_chk(ADDR_STATUS, 32'h10, 32'h10, "rd_err");
		rfault <= 1'b0;
		tick(2100);
		rd_chk(ADDR_STATUS, 32'h10, 32'h0, "rd_err");
	endtask : t_clock

	task t_square;
		logic any;
		any = 1'b0;
		halfp(11, 20);
		halfp(9, 2000);
		setc(8, 1'b1);
		tick(2);
		for (int i = 0; i < 30; i++)
		begin
			bus(1'b0, ADDR_STATUS, 32'h0);
			any |= v[9];
			tick(100);
		end
		chk("one_sec", any, 1'b0);
		halfp(10, 200);
		setc(8, 1'b0);
	endtask : t_square

	initial
	begin
		tick(16);
		sys_rst_i <= 1'b0;
		tick(1);
		t_reset();
		t_status();
		t_cmp();
		t_cmd();
		t_hold();
		t_irq_catch();
		t_bm();
		t_clock();
		t_square();
		end_sim();
	end

	initial
	begin
		tick(90000);
		n_mismatch++;
		end_sim();
	end
endmodule : tb
